// ==== rtl/lced_decoder.sv ====
// Legacy context entry decoder with an Avalon-MM register slave.
// Software loads a context entry and a request, the block returns the action.
// Assumes one 10 MHz clock and an Avalon master that honours waitrequest.
`timescale 1ns/1ps
module lced_decoder
  import lced_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             avs_response_err,
  output logic             fault_pulse,
  output logic [1:0]       action_out,
  output logic [15:0]      domain_tag_out
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [LCED_ENTRY_W-1:0] entry;
  logic [4:0]              supported_width_cap;
  logic                    device_tlb_cap;
  logic                    passthrough_cap;
  logic [6:0]              host_addr_width;
  logic [LCED_ADDR_W-1:0]  req_addr;
  lced_result_t            result;
  logic [15:0]             fault_count;
  logic                    busy;
  logic                    go;
  logic                    req_pasid;
  lced_req_kind_t          req_kind;

  // ----------------------------------------------------------------
  // Entry fields
  // ----------------------------------------------------------------
  logic                  present;
  logic                  fault_suppress;
  logic [1:0]            xlate_type;
  logic [2:0]            addr_width_sel;
  logic [LCED_PTR_W-1:0] second_level_table_ptr;
  logic [LCED_TAG_W-1:0] domain_tag;

  // Bits 70:67 and 11:4 are deliberately never sliced out here
  assign present                = entry[LCED_PRESENT_BIT];
  assign fault_suppress         = entry[LCED_SUPPRESS_BIT];
  assign xlate_type             = entry[LCED_TYPE_HI:LCED_TYPE_LO];
  assign addr_width_sel         = entry[LCED_WIDTH_HI:LCED_WIDTH_LO];
  assign second_level_table_ptr = entry[LCED_PTR_HI:LCED_PTR_LO];
  assign domain_tag             = entry[LCED_TAG_HI:LCED_TAG_LO];

  // ----------------------------------------------------------------
  // Width and range helpers
  // ----------------------------------------------------------------
  logic [6:0]             width_bits;
  logic [2:0]             levels;
  logic                   width_legal;
  logic                   addr_over;
  logic                   ptr_over;
  logic [LCED_ADDR_W-1:0] ptr_full;

  assign ptr_full = {second_level_table_ptr, 12'h000};

  lced_width_dec u_width
  (
    .addr_width_sel      (addr_width_sel),
    .supported_width_cap (supported_width_cap),
    .width_bits          (width_bits),
    .levels              (levels),
    .legal               (width_legal)
  );

  lced_range_chk u_range
  (
    .addr            (req_addr),
    .width_bits      (width_bits),
    .ptr_full        (ptr_full),
    .host_addr_width (host_addr_width),
    .addr_over       (addr_over),
    .ptr_over        (ptr_over)
  );

  // ----------------------------------------------------------------
  // Decision logic
  // ----------------------------------------------------------------
  logic         type_rsvd;
  logic         uses_walk;
  lced_action_t next_action;
  logic [7:0]   next_cause;

  always_comb
  begin
    type_rsvd = 1'b0;
    uses_walk = 1'b0;
    case (xlate_type)
      LCED_TT_SECOND:
      begin
        uses_walk = 1'b1;
      end
      LCED_TT_DEVTLB:
      begin
        type_rsvd = !device_tlb_cap;
        uses_walk = 1'b1;
      end
      LCED_TT_PASS:
      begin
        type_rsvd = !passthrough_cap;
      end
      default:
      begin
        type_rsvd = 1'b1;
      end
    endcase
  end

  always_comb
  begin
    next_action = LCED_ACT_BLOCK;
    next_cause  = 8'h00;
    if (req_pasid)
    begin
      next_cause[LCED_F_PASID] = 1'b1;
    end
    else if (!present)
    begin
      next_cause[LCED_F_ABSENT] = 1'b1;
    end
    else if (type_rsvd)
    begin
      next_cause[LCED_F_RSVD_TT] = 1'b1;
    end
    else if (!width_legal && uses_walk)
    begin
      // Pass-through width is software's duty, not checked here
      next_cause[LCED_F_RSVD_AW] = 1'b1;
    end
    else if (uses_walk && ptr_over)
    begin
      next_cause[LCED_F_PTR] = 1'b1;
    end
    else
    begin
      case (xlate_type)
        LCED_TT_SECOND:
        begin
          if (req_kind != LCED_REQ_UNTRANSLATED)
            next_cause[LCED_F_KIND] = 1'b1;
          else if (addr_over)
            next_cause[LCED_F_RANGE] = 1'b1;
          else
            next_action = LCED_ACT_WALK;
        end
        LCED_TT_DEVTLB:
        begin
          if (req_kind == LCED_REQ_UNTRANSLATED && addr_over)
            next_cause[LCED_F_RANGE] = 1'b1;
          else if (req_kind == LCED_REQ_TRANSLATED)
            next_action = LCED_ACT_ACCEPT;
          else
            next_action = LCED_ACT_WALK;
        end
        LCED_TT_PASS:
        begin
          if (req_kind != LCED_REQ_UNTRANSLATED)
            next_cause[LCED_F_KIND] = 1'b1;
          else if (addr_over && width_legal)
            next_cause[LCED_F_RANGE] = 1'b1;
          else
            next_action = LCED_ACT_PASS;
        end
        default:
        begin
          next_cause[LCED_F_RSVD_TT] = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, answer at the second edge
  // ----------------------------------------------------------------
  logic access;

  assign access = (avs_read || avs_write) && !busy;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busy <= 1'b0;
    else
      busy <= access;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !access;
  end

  // Byte lanes merge into the addressed entry word; the other registers ignore byteenable
  function automatic logic [31:0] lced_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction : lced_merge

  logic wr_now;
  assign wr_now = access && avs_write;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      entry <= {LCED_ENTRY_W{1'b0}};
    else if (wr_now && avs_address[5:4] == 2'b00)
      entry[avs_address[3:2]*32 +: 32] <= lced_merge(entry[avs_address[3:2]*32 +: 32], avs_writedata,
                                                     avs_byteenable);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      supported_width_cap <= LCED_SUPPORTED_WIDTH_CAP_RST;
      device_tlb_cap      <= LCED_DT_RST;
      passthrough_cap     <= LCED_PT_RST;
      host_addr_width     <= LCED_HAW_RST;
    end
    else if (wr_now && avs_address == LCED_REG_CAP)
    begin
      supported_width_cap <= avs_writedata[LCED_CAP_SUPPORTED_WIDTH_CAP_HI:LCED_CAP_SUPPORTED_WIDTH_CAP_LO];
      device_tlb_cap      <= avs_writedata[LCED_CAP_DT_BIT];
      passthrough_cap     <= avs_writedata[LCED_CAP_PT_BIT];
      host_addr_width     <= avs_writedata[LCED_CAP_HAW_HI:LCED_CAP_HAW_LO];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      req_addr <= {LCED_ADDR_W{1'b0}};
    else if (wr_now && avs_address == LCED_REG_ADDR_LO)
      req_addr[31:0] <= avs_writedata;
    else if (wr_now && avs_address == LCED_REG_ADDR_HI)
      req_addr[63:32] <= avs_writedata;
  end

  // Writing the request register launches one decision next cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      go        <= 1'b0;
      req_pasid <= 1'b0;
      req_kind  <= LCED_REQ_UNTRANSLATED;
    end
    else
    begin
      go <= wr_now && avs_address == LCED_REG_REQ;
      if (wr_now && avs_address == LCED_REG_REQ)
      begin
        req_pasid <= avs_writedata[2];
        req_kind  <= (avs_writedata[1:0] == 2'b11) ? LCED_REQ_UNTRANSLATED : lced_req_kind_t'(avs_writedata[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------
  logic next_fault;
  assign next_fault = |next_cause;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      result <= '0;
    else if (go)
    begin
      result.valid  <= 1'b1;
      result.action <= next_action;
      result.fault  <= next_fault;
      result.report <= next_fault && !fault_suppress;
      result.cause  <= next_cause;
      result.levels <= uses_walk ? levels : 3'h0;
      result.tag    <= present ? domain_tag : '0;
      result.ptr    <= (uses_walk && present) ? second_level_table_ptr : '0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fault_count <= 16'h0000;
    else if (go && next_fault && !fault_suppress)
      fault_count <= fault_count + 16'h0001;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fault_pulse <= 1'b0;
    else
      fault_pulse <= go && next_fault && !fault_suppress;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      action_out     <= 2'h0;
      domain_tag_out <= 16'h0000;
    end
    else if (go)
    begin
      action_out     <= next_action;
      domain_tag_out <= present ? domain_tag : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Read data and error answer
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_miss;

  always_comb
  begin
    rd_mux  = LCED_ZERO32;
    rd_miss = 1'b0;
    case (avs_address)
      LCED_REG_ENTRY0:  rd_mux = entry[31:0];
      LCED_REG_ENTRY1:  rd_mux = entry[63:32];
      LCED_REG_ENTRY2:  rd_mux = entry[95:64];
      LCED_REG_ENTRY3:  rd_mux = entry[127:96];
      LCED_REG_CAP:     rd_mux = {17'h00000, host_addr_width, 1'b0, passthrough_cap, device_tlb_cap,
                                  supported_width_cap};
      LCED_REG_ADDR_LO: rd_mux = req_addr[31:0];
      LCED_REG_ADDR_HI: rd_mux = req_addr[63:32];
      LCED_REG_REQ:     rd_mux = {29'h0000000, req_pasid, req_kind};
      LCED_REG_RESULT:  rd_mux = {result.tag, result.cause, result.levels, result.report, result.fault,
                                  result.action, result.valid};
      LCED_REG_PTR_LO:  rd_mux = {result.ptr[19:0], 12'h000};
      LCED_REG_PTR_HI:  rd_mux = result.ptr[51:20];
      LCED_REG_FCOUNT:  rd_mux = {16'h0000, fault_count};
      default:          rd_miss = 1'b1;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      avs_readdata     <= LCED_ZERO32;
      avs_response_err <= 1'b0;
    end
    else
    begin
      avs_readdata     <= (access && avs_read) ? rd_mux : LCED_ZERO32;
      avs_response_err <= access && rd_miss;
    end
  end

endmodule : lced_decoder

// ==== rtl/lced_pkg.sv ====
// Package for the legacy context entry decoder: entry field layout, encodings,
// capability defaults, Avalon register map and the result carrier struct.
// Assumes a 10 MHz single clock domain and a 32-bit Avalon-MM register port.
package lced_pkg;

  // ----------------------------------------------------------------
  // Context entry field positions (low 128-bit entry)
  // ----------------------------------------------------------------
  localparam int LCED_PRESENT_BIT   = 0;
  localparam int LCED_SUPPRESS_BIT  = 1;
  localparam int LCED_TYPE_LO       = 2;
  localparam int LCED_TYPE_HI       = 3;
  localparam int LCED_RSV_LO        = 4;
  localparam int LCED_RSV_HI        = 11;
  localparam int LCED_PTR_LO        = 12;
  localparam int LCED_PTR_HI        = 63;
  localparam int LCED_WIDTH_LO      = 64;
  localparam int LCED_WIDTH_HI      = 66;
  localparam int LCED_IGN_LO        = 67;
  localparam int LCED_IGN_HI        = 70;
  localparam int LCED_TAG_LO        = 72;
  localparam int LCED_TAG_HI        = 87;
  localparam int LCED_ENTRY_W       = 128;
  localparam int LCED_PTR_W         = LCED_PTR_HI - LCED_PTR_LO + 1;
  localparam int LCED_TAG_W         = LCED_TAG_HI - LCED_TAG_LO + 1;
  localparam int LCED_ADDR_W        = 64;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] LCED_TT_SECOND  = 2'h0;
  localparam logic [1:0] LCED_TT_DEVTLB  = 2'h1;
  localparam logic [1:0] LCED_TT_PASS    = 2'h2;
  localparam logic [1:0] LCED_TT_RSVD    = 2'h3;
  localparam logic [2:0] LCED_AW_39      = 3'h1;
  localparam logic [2:0] LCED_AW_48      = 3'h2;
  localparam logic [2:0] LCED_AW_57      = 3'h3;
  localparam logic [6:0] LCED_BITS_39    = 7'h27;
  localparam logic [6:0] LCED_BITS_48    = 7'h30;
  localparam logic [6:0] LCED_BITS_57    = 7'h39;
  localparam logic [2:0] LCED_LVL_3      = 3'h3;
  localparam logic [2:0] LCED_LVL_4      = 3'h4;
  localparam logic [2:0] LCED_LVL_5      = 3'h5;

  typedef enum logic [1:0] {
    LCED_REQ_UNTRANSLATED = 2'b00,
    LCED_REQ_TRANSLATED   = 2'b01,
    LCED_REQ_XLATE        = 2'b10
  } lced_req_kind_t;

  typedef enum logic [1:0] {
    LCED_ACT_BLOCK  = 2'b00,
    LCED_ACT_WALK   = 2'b01,
    LCED_ACT_PASS   = 2'b10,
    LCED_ACT_ACCEPT = 2'b11
  } lced_action_t;

  // Fault causes, one-hot bit positions
  localparam int LCED_F_PASID    = 0;
  localparam int LCED_F_ABSENT   = 1;
  localparam int LCED_F_RSVD_TT  = 2;
  localparam int LCED_F_RSVD_AW  = 3;
  localparam int LCED_F_RANGE    = 4;
  localparam int LCED_F_KIND     = 5;
  localparam int LCED_F_PTR      = 6;
  localparam int LCED_F_W        = 7;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [5:0] LCED_REG_ENTRY0  = 6'h00;
  localparam logic [5:0] LCED_REG_ENTRY1  = 6'h04;
  localparam logic [5:0] LCED_REG_ENTRY2  = 6'h08;
  localparam logic [5:0] LCED_REG_ENTRY3  = 6'h0c;
  localparam logic [5:0] LCED_REG_CAP     = 6'h10;
  localparam logic [5:0] LCED_REG_ADDR_LO = 6'h14;
  localparam logic [5:0] LCED_REG_ADDR_HI = 6'h18;
  localparam logic [5:0] LCED_REG_REQ     = 6'h1c;
  localparam logic [5:0] LCED_REG_RESULT  = 6'h20;
  localparam logic [5:0] LCED_REG_PTR_LO  = 6'h24;
  localparam logic [5:0] LCED_REG_PTR_HI  = 6'h28;
  localparam logic [5:0] LCED_REG_FCOUNT  = 6'h2c;

  // Capability field positions in LCED_REG_CAP
  localparam int LCED_CAP_SUPPORTED_WIDTH_CAP_LO = 0;
  localparam int LCED_CAP_SUPPORTED_WIDTH_CAP_HI = 4;
  localparam int LCED_CAP_DT_BIT   = 5;
  localparam int LCED_CAP_PT_BIT   = 6;
  localparam int LCED_CAP_HAW_LO   = 8;
  localparam int LCED_CAP_HAW_HI   = 14;

  // Capability reset values
  localparam logic [4:0]  LCED_SUPPORTED_WIDTH_CAP_RST = 5'h0e;
  localparam logic        LCED_DT_RST    = 1'b1;
  localparam logic        LCED_PT_RST    = 1'b1;
  localparam logic [6:0]  LCED_HAW_RST   = 7'h34;
  localparam logic [31:0] LCED_ZERO32    = 32'h0000_0000;

  // Decoded request outcome
  typedef struct packed {
    logic                    valid;
    lced_action_t            action;
    logic                    fault;
    logic                    report;
    logic [7:0]              cause;
    logic [2:0]              levels;
    logic [LCED_TAG_W-1:0]   tag;
    logic [LCED_PTR_W-1:0]   ptr;
  } lced_result_t;

endpackage : lced_pkg

// ==== rtl/lced_range_chk.sv ====
// Range checker: flags an address above 2^width-1 and pointer bits at or
// above the host address width. Combinational, one generate loop with one iteration per bit.
`timescale 1ns/1ps
module lced_range_chk
  import lced_pkg::*;
(
  input  wire logic [LCED_ADDR_W-1:0] addr,
  input  wire logic [6:0]             width_bits,
  input  wire logic [LCED_ADDR_W-1:0] ptr_full,
  input  wire logic [6:0]             host_addr_width,
  output logic                        addr_over,
  output logic                        ptr_over
);

  logic [LCED_ADDR_W-1:0] addr_hit;
  logic [LCED_ADDR_W-1:0] ptr_hit;

  genvar gi;
  generate
    for (gi = 0; gi < LCED_ADDR_W; gi = gi + 1)
    begin : g_bit
      assign addr_hit[gi] = addr[gi] && (7'(gi) >= width_bits);
      assign ptr_hit[gi]  = ptr_full[gi] && (7'(gi) >= host_addr_width);
    end
  endgenerate

  assign addr_over = |addr_hit;
  assign ptr_over  = |ptr_hit;

endmodule : lced_range_chk

// ==== rtl/lced_width_dec.sv ====
// Address width decoder: maps the width selector to bits and table levels.
// Purely combinational; used by the context entry decoder.
`timescale 1ns/1ps
module lced_width_dec
  import lced_pkg::*;
(
  input  wire logic [2:0] addr_width_sel,
  input  wire logic [4:0] supported_width_cap,
  output logic      [6:0] width_bits,
  output logic      [2:0] levels,
  output logic            legal
);

  always_comb
  begin
    width_bits = 7'h00;
    levels     = 3'h0;
    legal      = 1'b0;
    case (addr_width_sel)
      LCED_AW_39:
      begin
        width_bits = LCED_BITS_39;
        levels     = LCED_LVL_3;
        legal      = supported_width_cap[LCED_AW_39];
      end
      LCED_AW_48:
      begin
        width_bits = LCED_BITS_48;
        levels     = LCED_LVL_4;
        legal      = supported_width_cap[LCED_AW_48];
      end
      LCED_AW_57:
      begin
        width_bits = LCED_BITS_57;
        levels     = LCED_LVL_5;
        legal      = supported_width_cap[LCED_AW_57];
      end
      default:
      begin
        legal = 1'b0;
      end
    endcase
  end

endmodule : lced_width_dec

// ==== test/lced_decoder_asserts.sv ====
// Port checker for the context entry decoder.
// Assumes one clock clk and asynchronous active-high rst.
`timescale 1ns/1ps
module lced_decoder_asserts
  import lced_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        avs_response_err,
  input wire logic        fault_pulse,
  input wire logic [1:0]  action_out,
  input wire logic [15:0] domain_tag_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_rdz;
    avs_waitrequest |-> avs_readdata == LCED_ZERO32;
  endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside answer");
  property p_err;
    avs_response_err |-> !avs_waitrequest && avs_readdata == LCED_ZERO32;
  endproperty
  a_err: assert property (p_err) else $error("error without answer");
  property p_fp;
    fault_pulse |=> !fault_pulse;
  endproperty
  a_fp: assert property (p_fp) else $error("fault pulse too long");
  property p_fblk;
    fault_pulse |-> action_out == LCED_ACT_BLOCK;
  endproperty
  a_fblk: assert property (p_fblk) else $error("fault not blocked");
  property p_fwr;
    fault_pulse |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3);
  endproperty
  a_fwr: assert property (p_fwr) else $error("fault without request");
  property p_act;
    $changed(action_out) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3);
  endproperty
  a_act: assert property (p_act) else $error("action changed alone");
  property p_tag;
    $changed(domain_tag_out) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3);
  endproperty
  a_tag: assert property (p_tag) else $error("tag changed alone");
endmodule : lced_decoder_asserts

bind lced_decoder lced_decoder_asserts u_lced_decoder_asserts (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response_err(avs_response_err), .fault_pulse(fault_pulse), .action_out(action_out),
  .domain_tag_out(domain_tag_out));

// ==== test/lced_decoder_tb_top.sv ====
// Bench for lced_decoder: random entries and requests against a behavioural model.
// Assumes the requester model drives the register port and the checker is bound.
`timescale 1ns/1ps
module lced_decoder_tb_top
  import lced_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest, avs_response_err, fault_pulse;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0]  action_out;
  logic [15:0] domain_tag_out;
  int          fail_count = 0;
  int          n_tests = 0;
  int          n_pulse = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (fault_pulse === 1'b1) n_pulse <= n_pulse + 1;
  lced_decoder u_lced_decoder (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err), .fault_pulse(fault_pulse),
    .action_out(action_out), .domain_tag_out(domain_tag_out));
  lced_ep_model u_lced_ep_model (.clk(clk), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic void model(input logic [127:0] e, input int k, input bit pas, input bit nocap,
                                input logic [63:0] a, output int act, output bit flt);
    int tt;
    bit leg, over, untr;
    tt = e[3:2];
    leg = e[66:64] >= 1 && e[66:64] <= 3;
    over = leg ? (a >> (30 + 9 * e[66:64])) != 0 : 1'b0;
    untr = k == 0 || k == 3;
    act = LCED_ACT_BLOCK;
    flt = 1'b1;
    if (pas || !e[0] || tt == 3 || (nocap && tt != 0)) act = LCED_ACT_BLOCK;
    else if (tt == 2)
    begin
      if (untr && !over) {act, flt} = {LCED_ACT_PASS, 1'b0};
    end
    else if (!leg || e[63:52] != 0) act = LCED_ACT_BLOCK;
    else if (tt == 1 && k == 1) {act, flt} = {LCED_ACT_ACCEPT, 1'b0};
    else if (tt == 1 && k == 2) {act, flt} = {LCED_ACT_WALK, 1'b0};
    else if (untr && !over) {act, flt} = {LCED_ACT_WALK, 1'b0};
  endfunction : model
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  initial
  begin
    #3_000_000;
    fail_count++;
    final_report();
  end
  initial
  begin
    logic [127:0] ent;
    logic [63:0]  addr;
    logic [31:0]  q;
    logic         e;
    int           act, np;
    bit           pas, flt;
    void'($urandom(48262));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    u_lced_ep_model.xfer(1'b0, LCED_REG_CAP, 32'h0, q, e);
    check(q, {LCED_HAW_RST, 1'b0, LCED_PT_RST, LCED_DT_RST, LCED_SUPPORTED_WIDTH_CAP_RST});
    u_lced_ep_model.xfer(1'b0, 6'h30, 32'h0, q, e);
    check(q, 32'h0);
    check(e, 1'b1);
    u_lced_ep_model.xfer(1'b1, 6'h34, 32'hffff_ffff, q, e);
    check(e, 1'b1);
    for (int i = 0; i < 48; i++)
    begin
      ent = {$urandom, $urandom, $urandom, $urandom};
      ent[3:2] = 2'(i);
      pas = ($urandom % 6) == 0;
      ent[0] = ($urandom % 5) != 0;
      if ($urandom % 4 != 0) ent[66:64] = 3'(1 + $urandom % 3);
      if (i % 4 == 2 && $urandom % 2) ent[66:64] = LCED_AW_57;
      if ($urandom % 4 != 0) ent[63:52] = 12'h000;
      addr = (64'h1 << (39 + 9 * ($urandom % 3))) - 64'($urandom % 2);
      if (i == 24)
        u_lced_ep_model.xfer(1'b1, LCED_REG_CAP, {17'h0, LCED_HAW_RST, 3'h0, LCED_SUPPORTED_WIDTH_CAP_RST}, q, e);
      u_lced_ep_model.load_entry(ent);
      u_lced_ep_model.xfer(1'b1, LCED_REG_ADDR_LO, addr[31:0], q, e);
      u_lced_ep_model.xfer(1'b1, LCED_REG_ADDR_HI, addr[63:32], q, e);
      np = n_pulse;
      u_lced_ep_model.xfer(1'b1, LCED_REG_REQ, {29'h0, pas, 2'(i / 4)}, q, e);
      u_lced_ep_model.xfer(1'b0, LCED_REG_RESULT, 32'h0, q, e);
      model(ent, (i / 4) % 4, pas, i >= 24, addr, act, flt);
      check(q[0], 1'b1);
      check(q[2:1], act);
      check(q[3], flt);
      check(q[4], flt && !ent[1]);
      check(q[31:16], ent[0] ? ent[87:72] : 16'h0);
      check(action_out, act);
      check(n_pulse - np, flt && !ent[1]);
      check(domain_tag_out, ent[0] ? ent[87:72] : 16'h0);
      check(q[15:8] != 0, flt);
      if (act == LCED_ACT_WALK)
      begin
        check(q[7:5], ent[66:64] + 2);
        u_lced_ep_model.xfer(1'b0, LCED_REG_PTR_LO, 32'h0, q, e);
        check(q, {ent[31:12], 12'h000});
      end
    end
    final_report();
  end
endmodule : lced_decoder_tb_top

// ==== test/lced_ep_model.sv ====
// Requester-side model: an Avalon master that loads entries and issues requests.
// Assumes the decoder answers each request with one low cycle of waitrequest.
`timescale 1ns/1ps
module lced_ep_model
  import lced_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic        avs_response_err,
  output logic      [5:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata
);
  initial
  begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  // Called just after a rising edge; returns just after one
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    q = avs_readdata;
    e = avs_response_err;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released lines must not keep showing the old request
    avs_address <= ~a;
    avs_writedata <= ~d;
    @(posedge clk);
  endtask : xfer
  task automatic load_entry(input logic [127:0] ent);
    logic [31:0] q;
    logic        e;
    ent[11:4] = 8'h00;
    for (int w = 0; w < 4; w++)
      xfer(1'b1, 6'(4 * w), ent[32 * w +: 32], q, e);
  endtask : load_entry
endmodule : lced_ep_model
